// ==== trigger_input_terminal_pkg.sv ====
// shared constants and types for the measurement trigger controller
package trigger_input_terminal_pkg;
    // ---------------------------------------------------------------
    // register map (byte addresses)
    // ---------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_DELAY  = 8'h04;
    localparam logic [7:0] OFS_CMD    = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0c;
    localparam logic [7:0] OFS_MODE   = 8'h10;
    localparam logic [7:0] OFS_RES    = 8'h14;
    localparam logic [7:0] OFS_VOLT   = 8'h18;
    // ---------------------------------------------------------------
    // field positions
    // ---------------------------------------------------------------
    localparam int CTRL_SRC_EXT  = 0;
    localparam int CTRL_DLY_EN   = 1;
    localparam int CTRL_REPEAT   = 2;
    localparam int CMD_ARM       = 0;
    localparam int CMD_SOFT_TRG  = 1;
    localparam int ST_B_IDLE     = 0;
    localparam int ST_B_WAIT     = 1;
    localparam int ST_B_DELAY    = 2;
    localparam int ST_B_MEAS     = 3;
    localparam int ST_B_EXEC_ERR = 8;
    localparam int ST_B_RANGE    = 9;
    localparam int ST_B_VALID    = 10;
    // ---------------------------------------------------------------
    // widths, reset values, limits
    // ---------------------------------------------------------------
    localparam int DLY_W  = 14;
    localparam int DATA_W = 32;
    localparam logic [DLY_W-1:0] DELAY_MAX   = 14'h270f; // 9.999 s in ms
    localparam logic [DLY_W-1:0] DELAY_RESET = 14'h0000;
    localparam logic [2:0]       CTRL_RESET  = 3'h0;
    localparam logic [1:0]       MODE_BOTH   = 2'h0;
    localparam logic [1:0]       MODE_RES    = 2'h1;
    localparam logic [1:0]       MODE_VOLT   = 2'h2;
    localparam logic             ADDR_RES    = 1'b0;
    localparam logic             ADDR_VOLT   = 1'b1;
    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int MS_NS         = 1000000;
    localparam int MS_CYCLES     = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PRESC_W       = 14;
    // ---------------------------------------------------------------
    // state types
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_WAIT    = 2'b01,
        ST_DELAY   = 2'b10,
        ST_MEASURE = 2'b11
    } trigger_input_terminal_state_t;
    typedef enum logic [1:0] {
        BUS_IDLE  = 2'b00,
        BUS_FETCH = 2'b01,
        BUS_DONE  = 2'b10
    } bus_state_t;
endpackage

// ==== meas_store.sv ====
// small memory holding the latest resistance and voltage readings
`timescale 1ns/1ps
module meas_store
    import trigger_input_terminal_pkg::*;
#(
    parameter int WIDTH = 32,
    parameter int DEPTH = 2
)(
    input  wire logic                     mclk,
    input  wire logic                     wr_en,
    input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
    input  wire logic [WIDTH-1:0]         wr_data,
    input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
    output logic      [WIDTH-1:0]         rd_data
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [WIDTH-1:0] rd_data_reg;

    // ---------------------------------------------------------------
    // storage
    // ---------------------------------------------------------------
    // no reset on the array so it maps onto plain ram cells
    always_ff @(posedge mclk)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
        rd_data_reg <= mem[rd_addr];
    end

    assign rd_data = rd_data_reg;
endmodule

// ==== delay_timer.sv ====
// millisecond countdown used to hold off measurement after a trigger
`timescale 1ns/1ps
module delay_timer
    import trigger_input_terminal_pkg::*;
#(
    parameter int CYCLES_PER_MS = MS_CYCLES
)(
    input  wire logic             mclk,
    input  wire logic             reset_n,
    input  wire logic             start,
    input  wire logic [DLY_W-1:0] interval_ms,
    output logic                  done
);
    localparam logic [PRESC_W-1:0] PRESC_LAST = PRESC_W'(CYCLES_PER_MS - 1);

    logic               run_reg,   run_next;
    logic [PRESC_W-1:0] presc_reg, presc_next;
    logic [DLY_W-1:0]   ms_reg,    ms_next;
    logic               done_reg,  done_next;

    // ---------------------------------------------------------------
    // countdown
    // ---------------------------------------------------------------
    // a zero interval finishes on the next edge, never waits a tick
    always_comb
    begin
        run_next   = run_reg;
        presc_next = presc_reg;
        ms_next    = ms_reg;
        done_next  = 1'b0;
        if (start)
        begin
            presc_next = '0;
            ms_next    = interval_ms;
            run_next   = (interval_ms != '0);
            done_next  = (interval_ms == '0);
        end
        else if (run_reg)
        begin
            if (presc_reg == PRESC_LAST)
            begin
                presc_next = '0;
                ms_next    = ms_reg - 1'b1;
                if (ms_reg == DLY_W'(1))
                begin
                    run_next  = 1'b0;
                    done_next = 1'b1;
                end
            end
            else
            begin
                presc_next = presc_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            run_reg   <= 1'b0;
            presc_reg <= '0;
            ms_reg    <= '0;
            done_reg  <= 1'b0;
        end
        else
        begin
            run_reg   <= run_next;
            presc_reg <= presc_next;
            ms_reg    <= ms_next;
            done_reg  <= done_next;
        end
    end

    assign done = done_reg;
endmodule

// ==== measurement_trigger_control.sv ====
// trigger sequencing and register file of the measurement controller
//
// Operation
// - an arm command while idle moves the sequencer into trigger-wait.
// - an arm command while repeat measurement is on is refused with an execution error.
// - with the internal source, arming gives one immediate measurement and then idle.
// - with the external source, arming waits for one outside trigger, measures once, then idles.
// - software picks internal or external; external accepts key, terminal or soft trigger.
// - the selected source can be read back.
// - a delay-enable flag is written and read back as on or off.
// - a delay interval of 0 to 9.999 s in whole milliseconds is stored.
// - the stored interval reads back as a millisecond count in that range.
// - the latest measurement for the active mode reads back without any trigger.
// - after a measurement the sequencer idles if repeat is off and rewaits if it is on.
// - triggers of any source are ignored while idle.
`timescale 1ns/1ps
module measurement_trigger_control
    import trigger_input_terminal_pkg::*;
#(
    parameter int CYCLES_PER_MS = MS_CYCLES
)(
    input  wire logic              mclk,
    input  wire logic              reset_n,
    input  wire logic [7:0]        avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [DATA_W-1:0] avs_writedata,
    input  wire logic [3:0]        avs_byteenable,
    output logic      [DATA_W-1:0] avs_readdata,
    output logic                   avs_waitrequest,
    input  wire logic              trigger_key_in,
    input  wire logic              trigger_input_terminal,
    input  wire logic              meas_done,
    input  wire logic [DATA_W-1:0] meas_res,
    input  wire logic [DATA_W-1:0] meas_volt,
    output logic                   meas_start,
    output logic                   trigger_wait,
    output logic                   outside_trigger_indicator
);
    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    // byte-lane merge for delay register writes
    function automatic logic [DATA_W-1:0] be_merge(input logic [DATA_W-1:0] old_v,
                                                   input logic [DATA_W-1:0] new_v,
                                                   input logic [3:0]        be);
        logic [DATA_W-1:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++)
        begin
            r[i*8 +: 8] = be[i] ? new_v[i*8 +: 8] : r[i*8 +: 8];
        end
        return r;
    endfunction

    // ---------------------------------------------------------------
    // declarations
    // ---------------------------------------------------------------
    bus_state_t        bus_reg,   bus_next;
    logic              wait_reg,  wait_next;
    logic [DATA_W-1:0] rdata_reg, rdata_next;
    logic [2:0]        ctrl_reg,  ctrl_next;
    logic [DLY_W-1:0]  delay_reg, delay_next;
    logic [1:0]        mode_reg,  mode_next;
    logic              eerr_reg,  eerr_next;
    logic              rerr_reg,  rerr_next;
    logic              valid_reg, valid_next;
    trigger_input_terminal_state_t       st_reg,    st_next;
    logic              start_reg, start_next;
    logic              volt_pend_reg, volt_pend_next;
    logic [DATA_W-1:0] volt_hold_reg, volt_hold_next;
    logic [2:0]        key_sync_reg, term_sync_reg;
    logic              ext_ind_reg, tw_reg;
    logic              wr_acc, arm_cmd, soft_trg, key_rise, term_rise, trigger_input_terminal_hit;
    logic              dly_start, dly_done, mem_wr, mem_wa, mem_ra;
    logic [DATA_W-1:0] mem_wd, mem_rd, merged;

    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    // stage 0 is only read by stage 1; edges come from stages 1 and 2
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            key_sync_reg  <= 3'h0;
            term_sync_reg <= 3'h0;
        end
        else
        begin
            key_sync_reg  <= {key_sync_reg[1:0], trigger_key_in};
            term_sync_reg <= {term_sync_reg[1:0], trigger_input_terminal};
        end
    end

    assign key_rise  = key_sync_reg[1] & ~key_sync_reg[2];
    assign term_rise = term_sync_reg[1] & ~term_sync_reg[2];

    // ---------------------------------------------------------------
    // avalon slave handshake
    // ---------------------------------------------------------------
    // two cycles of wait give the store time to deliver registered data
    assign wr_acc   = (bus_reg == BUS_DONE) & avs_write;
    assign arm_cmd  = wr_acc & (avs_address == OFS_CMD) & avs_byteenable[0]
                    & avs_writedata[CMD_ARM];
    assign soft_trg = wr_acc & (avs_address == OFS_CMD) & avs_byteenable[0]
                    & avs_writedata[CMD_SOFT_TRG];
    assign mem_ra   = (avs_address == OFS_VOLT) ? ADDR_VOLT : ADDR_RES;
    assign merged   = be_merge(DATA_W'(delay_reg), avs_writedata, avs_byteenable);

    always_comb
    begin
        bus_next   = bus_reg;
        wait_next  = wait_reg;
        rdata_next = rdata_reg;
        case (bus_reg)
            BUS_IDLE:
            begin
                if (avs_read | avs_write)
                begin
                    bus_next = BUS_FETCH;
                end
            end
            BUS_FETCH:
            begin
                bus_next  = BUS_DONE;
                wait_next = 1'b0;
                rdata_next = '0;
                if (avs_address == OFS_CTRL)
                begin
                    rdata_next[2:0] = ctrl_reg;
                end
                else if (avs_address == OFS_DELAY)
                begin
                    rdata_next[DLY_W-1:0] = delay_reg;
                end
                else if (avs_address == OFS_STATUS)
                begin
                    rdata_next[ST_B_MEAS:ST_B_IDLE] = 4'h1 << st_reg; // codes match bits
                    rdata_next[ST_B_EXEC_ERR] = eerr_reg;
                    rdata_next[ST_B_RANGE]    = rerr_reg;
                    rdata_next[ST_B_VALID]    = valid_reg;
                end
                else if (avs_address == OFS_MODE)
                begin
                    rdata_next[1:0] = mode_reg;
                end
                else if ((avs_address == OFS_RES && mode_reg != MODE_VOLT)
                         || (avs_address == OFS_VOLT && mode_reg != MODE_RES))
                begin
                    // fetch only reads the store, it never triggers
                    rdata_next = mem_rd;
                end
            end
            // the done cycle lands here and returns to idle
            default:
            begin
                bus_next  = BUS_IDLE;
                wait_next = 1'b1;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            bus_reg   <= BUS_IDLE;
            wait_reg  <= 1'b1;
            rdata_reg <= '0;
        end
        else
        begin
            bus_reg   <= bus_next;
            wait_reg  <= wait_next;
            rdata_reg <= rdata_next;
        end
    end

    // ---------------------------------------------------------------
    // configuration registers and sticky errors
    // ---------------------------------------------------------------
    // an error raised in the clearing cycle survives the clear
    always_comb
    begin
        ctrl_next  = ctrl_reg;
        delay_next = delay_reg;
        mode_next  = mode_reg;
        eerr_next  = eerr_reg;
        rerr_next  = rerr_reg;
        if (wr_acc & (avs_address == OFS_CTRL) & avs_byteenable[0])
        begin
            ctrl_next = avs_writedata[2:0];
        end
        else if (wr_acc & (avs_address == OFS_DELAY))
        begin
            // out-of-range values keep the old interval and raise the range flag
            rerr_next  = rerr_reg | (merged > DATA_W'(DELAY_MAX));
            delay_next = (merged > DATA_W'(DELAY_MAX)) ? delay_reg : merged[DLY_W-1:0];
        end
        else if (wr_acc & (avs_address == OFS_MODE) & avs_byteenable[0])
        begin
            mode_next = avs_writedata[1:0];
        end
        else if (wr_acc & (avs_address == OFS_STATUS) & avs_byteenable[1])
        begin
            eerr_next = eerr_reg & ~avs_writedata[ST_B_EXEC_ERR];
            rerr_next = rerr_reg & ~avs_writedata[ST_B_RANGE];
        end
        eerr_next = eerr_next | (arm_cmd & ctrl_reg[CTRL_REPEAT]);
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ctrl_reg    <= CTRL_RESET;
            delay_reg   <= DELAY_RESET;
            mode_reg    <= MODE_BOTH;
            eerr_reg    <= 1'b0;
            rerr_reg    <= 1'b0;
            ext_ind_reg <= 1'b0;
        end
        else
        begin
            ctrl_reg    <= ctrl_next;
            delay_reg   <= delay_next;
            mode_reg    <= mode_next;
            eerr_reg    <= eerr_next;
            rerr_reg    <= rerr_next;
            ext_ind_reg <= ctrl_next[CTRL_SRC_EXT];
        end
    end

    // ---------------------------------------------------------------
    // trigger sequencer
    // ---------------------------------------------------------------
    // internal source fires as soon as trigger-wait is reached
    assign trigger_input_terminal_hit  = ctrl_reg[CTRL_SRC_EXT] ?
                       (key_rise | term_rise | soft_trg) : 1'b1;
    assign dly_start = (st_reg == ST_WAIT) & trigger_input_terminal_hit & ctrl_reg[CTRL_DLY_EN];

    always_comb
    begin
        st_next    = st_reg;
        start_next = 1'b0;
        case (st_reg)
            ST_IDLE:
            begin
                // triggers are not looked at here; repeat on waits at once
                if (arm_cmd | ctrl_reg[CTRL_REPEAT])
                begin
                    st_next = ST_WAIT;
                end
            end
            ST_WAIT:
            begin
                if (trigger_input_terminal_hit)
                begin
                    st_next    = ctrl_reg[CTRL_DLY_EN] ? ST_DELAY : ST_MEASURE;
                    start_next = ~ctrl_reg[CTRL_DLY_EN];
                end
            end
            ST_DELAY:
            begin
                if (dly_done)
                begin
                    st_next    = ST_MEASURE;
                    start_next = 1'b1;
                end
            end
            ST_MEASURE:
            begin
                if (meas_done)
                begin
                    st_next = ctrl_reg[CTRL_REPEAT] ? ST_WAIT : ST_IDLE;
                end
            end
            default:
            begin
                st_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            st_reg    <= ST_IDLE;
            start_reg <= 1'b0;
            tw_reg    <= 1'b0;
        end
        else
        begin
            st_reg    <= st_next;
            start_reg <= start_next;
            tw_reg    <= (st_next == ST_WAIT);
        end
    end

    delay_timer #(.CYCLES_PER_MS (CYCLES_PER_MS)) u_delay (
        .mclk        (mclk),
        .reset_n     (reset_n),
        .start       (dly_start),
        .interval_ms (delay_reg),
        .done        (dly_done)
    );

    // ---------------------------------------------------------------
    // result capture
    // ---------------------------------------------------------------
    // one write port, so voltage follows resistance by one cycle
    assign mem_wr = (st_reg == ST_MEASURE & meas_done) | volt_pend_reg;
    assign mem_wa = volt_pend_reg ? ADDR_VOLT : ADDR_RES;
    assign mem_wd = volt_pend_reg ? volt_hold_reg : meas_res;

    always_comb
    begin
        volt_pend_next = (st_reg == ST_MEASURE) & meas_done;
        volt_hold_next = volt_pend_next ? meas_volt : volt_hold_reg;
        valid_next     = valid_reg | volt_pend_reg;
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            volt_pend_reg <= 1'b0;
            volt_hold_reg <= '0;
            valid_reg     <= 1'b0;
        end
        else
        begin
            volt_pend_reg <= volt_pend_next;
            volt_hold_reg <= volt_hold_next;
            valid_reg     <= valid_next;
        end
    end

    meas_store #(.WIDTH (DATA_W), .DEPTH (2)) u_store (
        .mclk    (mclk),
        .wr_en   (mem_wr),
        .wr_addr (mem_wa),
        .wr_data (mem_wd),
        .rd_addr (mem_ra),
        .rd_data (mem_rd)
    );

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign avs_readdata              = rdata_reg;
    assign avs_waitrequest           = wait_reg;
    assign meas_start                = start_reg;
    assign trigger_wait              = tw_reg;
    assign outside_trigger_indicator = ext_ind_reg;
endmodule

// ==== measurement_trigger_control_properties.sv ====
// port checker for the trigger controller
`timescale 1ns/1ps
module measurement_trigger_control_properties
    import trigger_input_terminal_pkg::*;
(
    input wire logic              mclk,
    input wire logic              reset_n,
    input wire logic [7:0]        avs_address,
    input wire logic              avs_read,
    input wire logic              avs_write,
    input wire logic [DATA_W-1:0] avs_readdata,
    input wire logic              avs_waitrequest,
    input wire logic              meas_start,
    input wire logic              trigger_wait,
    input wire logic              outside_trigger_indicator
);
    // --------------------------------------
    // bus answer and sequencer pulses
    // --------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    wire ack = avs_read && !avs_waitrequest; // read answered at this edge
    // a fresh request gets two wait cycles, then a one-cycle answer
    sequence s_new;
        (avs_read || avs_write) && !$past(avs_read || avs_write);
    endsequence
    sequence s_ans;
        avs_waitrequest [*2] ##1 !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    a_answer_two: assert property (s_new |-> s_ans)
        else $error("bus answer timing wrong");
    a_wait_single: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
        else $error("waitrequest low too long");
    a_start_pulse: assert property (meas_start |=> !meas_start)
        else $error("start longer than one cycle");
    a_start_leaves: assert property (meas_start |-> !trigger_wait)
        else $error("start while still waiting");
    a_source_read: assert property (ack && avs_address == OFS_CTRL
        |-> avs_readdata[CTRL_SRC_EXT] == outside_trigger_indicator) else $error("source bad");
    a_unmapped_zero: assert property (ack && avs_address > OFS_VOLT
        |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
    a_cmd_zero: assert property (ack && avs_address == OFS_CMD |-> avs_readdata == 32'h0)
        else $error("command read not zero");
    a_status_wait: assert property (ack && avs_address == OFS_STATUS && $stable(trigger_wait)
        |-> avs_readdata[ST_B_WAIT] == trigger_wait) else $error("status wait bit bad");
endmodule
bind measurement_trigger_control measurement_trigger_control_properties
    measurement_trigger_control_properties_i (.mclk, .reset_n, .avs_address, .avs_read,
    .avs_write, .avs_readdata, .avs_waitrequest, .meas_start, .trigger_wait,
    .outside_trigger_indicator);

// ==== front_end_model.sv ====
// behavioural measurement front end: one result pair per start
`timescale 1ns/1ps
module front_end_model
    import trigger_input_terminal_pkg::*;
#(
    parameter int LATENCY = 3
)(
    input  wire logic              mclk,
    input  wire logic              reset_n,
    input  wire logic              meas_start,
    output logic                   meas_done,
    output logic      [DATA_W-1:0] meas_res,
    output logic      [DATA_W-1:0] meas_volt
);
    int         cnt_reg;
    logic [7:0] seq_reg;
    // conversion countdown; results garbled while converting
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            cnt_reg <= 0;
        else
            cnt_reg <= meas_start ? LATENCY : (cnt_reg != 0 ? cnt_reg - 1 : 0);
        if (!reset_n)
            seq_reg <= 8'h00;
        else if (meas_start)
            seq_reg <= seq_reg + 8'h01;
    end
    assign meas_done = (cnt_reg == 1);
    assign meas_res  = (cnt_reg > 1) ? ~(32'h100 + seq_reg) : 32'h100 + seq_reg;
    assign meas_volt = (cnt_reg > 1) ? ~(32'h200 + seq_reg) : 32'h200 + seq_reg;
endmodule

// ==== measurement_trigger_control_tb_top.sv ====
// bench: register table, then trigger sequences by hand
`timescale 1ns/1ps
module measurement_trigger_control_tb_top
    import trigger_input_terminal_pkg::*;
;
    localparam int CPM = 4; // short millisecond keeps delay runs brief
    logic              mclk = 1'b0, reset_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
    logic [7:0]        avs_address = 8'h00;
    logic [DATA_W-1:0] avs_writedata = 32'h0;
    logic              trigger_key_in = 1'b0, trigger_input_terminal = 1'b0;
    logic [DATA_W-1:0] avs_readdata, meas_res, meas_volt, q;
    logic              avs_waitrequest, meas_start, trigger_wait, outside_trigger_indicator;
    logic              meas_done;
    int                mismatches = 0, num_checks = 0, starts = 0, cyc = 0, n, s0;
    logic [7:0]        r_a [6] = '{OFS_DELAY, OFS_DELAY, OFS_MODE, OFS_CTRL, 8'h1c, OFS_CMD};
    logic [31:0]       r_w [6] = '{32'h270f, 32'h2710, 32'h2, 32'h2, 32'h5, 32'h0};
    logic [31:0]       r_r [6] = '{32'h270f, 32'h270f, 32'h2, 32'h2, 32'h0, 32'h0};
    measurement_trigger_control #(.CYCLES_PER_MS(CPM)) measurement_trigger_control_i (
        .mclk, .reset_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest, .trigger_key_in,
        .trigger_input_terminal, .meas_done, .meas_res, .meas_volt, .meas_start,
        .trigger_wait, .outside_trigger_indicator);
    front_end_model #(.LATENCY(3)) front_end_model_i (.mclk, .reset_n, .meas_start,
        .meas_done, .meas_res, .meas_volt);
    always #50 mclk = ~mclk;
    // start count and hang guard
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        starts <= starts + meas_start;
        if (cyc == 20000)
        begin
            mismatches = mismatches + 1;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // one request held until waitrequest is seen low; one idle edge after
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        avs_read <= !w;
        avs_write <= w;
        avs_address <= a;
        avs_writedata <= d;
        @(posedge mclk);
        while (avs_waitrequest !== 1'b0) @(posedge mclk);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(q, e);
    endtask
    // pins are held three cycles so the synchroniser sees the edge
    task automatic fire(input int k);
        if (k == 2) bus(1'b1, OFS_CMD, 32'h2);
        else
        begin
            trigger_input_terminal <= (k == 0);
            trigger_key_in <= (k == 1);
            repeat (3) @(posedge mclk);
            trigger_input_terminal <= 1'b0;
            trigger_key_in <= 1'b0;
            @(posedge mclk);
        end
    endtask
    task automatic go();
        n = 0;
        while (meas_start !== 1'b1 && n < 300)
        begin
            @(posedge mclk);
            n++;
        end
        chk(32'(meas_start), 32'h1);
        repeat (8) @(posedge mclk);
    endtask
    initial
    begin
        repeat (16) @(posedge mclk);
        reset_n <= 1'b1;
        @(posedge mclk);
        rd(OFS_CTRL, 32'h0);
        rd(OFS_DELAY, 32'h0);
        rd(OFS_STATUS, 32'h1);
        for (int i = 0; i < 6; i++)
        begin
            bus(1'b1, r_a[i], r_w[i]);
            rd(r_a[i], r_r[i]);
        end
        $display("test table done");
        bus(1'b1, OFS_CTRL, 32'h0);
        bus(1'b1, OFS_DELAY, 32'h2);
        bus(1'b1, OFS_CMD, 32'h1);
        go();
        chk(32'(trigger_wait), 32'h0);
        rd(OFS_RES, 32'h0);
        rd(OFS_VOLT, 32'h200 + 32'(starts));
        bus(1'b1, OFS_MODE, 32'h0);
        rd(OFS_RES, 32'h100 + 32'(starts));
        bus(1'b1, OFS_CTRL, 32'h1);
        s0 = starts;
        for (int k = 0; k < 3; k++) fire(k);
        repeat (10) @(posedge mclk);
        chk(32'(starts), 32'(s0));
        chk(32'(outside_trigger_indicator), 32'h1);
        for (int k = 0; k < 3; k++)
        begin
            bus(1'b1, OFS_CMD, 32'h1);
            repeat (10) @(posedge mclk);
            chk(32'(starts), 32'(s0 + k));
            chk(32'(trigger_wait), 32'h1);
            fire(k);
            go();
            chk(32'(trigger_wait), 32'h0);
        end
        $display("test external done");
        bus(1'b1, OFS_CTRL, 32'h3);
        bus(1'b1, OFS_CMD, 32'h1);
        fire(2);
        go();
        chk(32'(n >= 2 * CPM - 1 && n <= 2 * CPM + 4), 32'h1);
        bus(1'b1, OFS_CTRL, 32'h5);
        bus(1'b1, OFS_CMD, 32'h1);
        rd(OFS_STATUS, 32'h702);
        chk(32'(q[ST_B_EXEC_ERR]), 32'h1);
        fire(2);
        go();
        chk(32'(trigger_wait), 32'h1);
        $display("test delay and repeat done");
        print_verdict();
    end
endmodule
